// file: src/sartmp_pkg.sv
// Constants, types and helpers shared by the auxiliary/temperature controller
package sartmp_pkg;

	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned MS_PER_S        = 1000;
	localparam int unsigned IRQ_PULSE_MS    = 2;
	localparam int unsigned IRQ_PULSE_CYC   = IRQ_PULSE_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned AUTO_TICK_MS    = 1;
	localparam int unsigned AUTO_TICK_CYC   = AUTO_TICK_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned TEMP_BIAS_RATIO = 82;
	localparam int unsigned BATT_PRESCALE   = 5;
	localparam int unsigned BUF_DEPTH       = 64;
	localparam int unsigned CODE_W          = 12;

	// Byte addresses of the register words
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_CMD   = 8'h04;
	localparam logic [7:0] ADDR_BATT  = 8'h08;
	localparam logic [7:0] ADDR_AUTO  = 8'h10;
	localparam logic [7:0] ADDR_TMIN  = 8'h14;
	localparam logic [7:0] ADDR_TMAX  = 8'h18;
	localparam logic [7:0] ADDR_TFLAG = 8'h1c;
	localparam logic [7:0] ADDR_RES_A = 8'h20;
	localparam logic [7:0] ADDR_RES_B = 8'h24;
	localparam logic [7:0] ADDR_RES_V = 8'h28;
	localparam logic [7:0] ADDR_RES_T1 = 8'h2c;
	localparam logic [7:0] ADDR_RES_T2 = 8'h30;
	localparam logic [7:0] ADDR_BUF   = 8'h34;
	localparam logic [7:0] ADDR_BUFDAT = 8'h38;

	// Field positions
	localparam int unsigned CTRL_SELF_BIT  = 7;
	localparam int unsigned CTRL_RES_LSB   = 5;
	localparam int unsigned CMD_FN_LSB     = 2;
	localparam int unsigned CMD_BUSY_BIT   = 0;
	localparam int unsigned CMD_REFUSE_BIT = 1;
	localparam int unsigned BATT_MODE_BIT  = 0;
	localparam int unsigned AUTO_EN_BIT    = 0;
	localparam int unsigned AUTO_IRQ_BIT   = 1;
	localparam int unsigned AUTO_PIN_BIT   = 2;
	localparam int unsigned AUTO_IVL_LSB   = 8;
	localparam int unsigned BUF_EN_BIT     = 7;
	localparam int unsigned BUF_FULL_BIT   = 1;
	localparam int unsigned BUF_EMPTY_BIT  = 0;
	localparam int unsigned BDAT_FULL_BIT  = 15;
	localparam int unsigned BDAT_EMPTY_BIT = 14;

	// Reset values
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [15:0] AUTO_RST = 16'h0000;
	localparam logic [11:0] TMIN_RST = 12'h000;
	localparam logic [11:0] TMAX_RST = 12'hfff;

	typedef enum logic [1:0] {
		RES_12  = 2'h0,
		RES_8   = 2'h1,
		RES_10  = 2'h2,
		RES_12B = 2'h3
	} sartmp_res_t;

	typedef enum logic [3:0] {
		FN_IDLE      = 4'h0,
		FN_AUX_A     = 4'h1,
		FN_AUX_B     = 4'h2,
		FN_VBAT      = 4'h3,
		FN_TEMP      = 4'h4,
		FN_TEMP_DIFF = 4'h5,
		FN_SCAN      = 4'h6
	} sartmp_fn_t;

	typedef enum logic [2:0] {
		CH_AUX_A   = 3'h0,
		CH_AUX_B   = 3'h1,
		CH_VBAT    = 3'h2,
		CH_TEMP_LO = 3'h3,
		CH_TEMP_HI = 3'h4
	} sartmp_ch_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_START = 3'h1,
		ST_WAIT  = 3'h3,
		ST_STORE = 3'h2
	} sartmp_st_t;

	typedef struct packed {
		logic [7:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} sartmp_avs_req_t;

	typedef struct packed {
		logic        start;
		sartmp_ch_t  chan;
		logic        bias_hi;
		sartmp_res_t res;
	} sartmp_adc_t;

	function automatic logic [11:0] res_max(input sartmp_res_t r);
		unique case (r)
			RES_8:   res_max = 12'h0ff;
			RES_10:  res_max = 12'h3ff;
			RES_12,
			RES_12B: res_max = 12'hfff;
		endcase
	endfunction

endpackage

// file: src/sartmp_scale.sv
// Result scaling for the auxiliary and battery inputs
`timescale 1ns/1ps
module sartmp_scale (
	input  wire logic [11:0]         code,      // Synchronised converter code
	input  sartmp_pkg::sartmp_res_t  res,       // Programmed resolution
	input  wire logic                batt_mode, // Battery-voltage mode
	input  wire logic                is_vbat,   // Current channel is battery
	output logic [11:0]              value      // Result to store
);
	import sartmp_pkg::*;

	logic [11:0] lim;
	logic [11:0] raw;
	logic [14:0] prod;

	always_comb begin
		lim  = res_max(res);
		raw  = code & lim;
		prod = 15'(raw) * 15'(BATT_PRESCALE);
		if (is_vbat && !batt_mode) begin
			// Saturate: the x5 rescale can overshoot the full-scale code
			value = (prod > {3'h0, lim}) ? lim : prod[11:0];
		end else begin
			value = raw;
		end
	end

endmodule // sartmp_scale

// file: src/sartmp_ctrl.sv
// Auxiliary, battery and temperature conversion controller with result FIFO
`timescale 1ns/1ps
// Functional notes
// - Single or differential temperature mode; second at x82 bias.
// - Auto mode starts a temperature conversion each interval.
// - Auto results outside min/max set a flag that a read clears.
// - Optional 2 ms high pulse on a general-purpose pin on violation.
// - Temperature conversions only accepted in host-controlled mode.
// - Auxiliary inputs converted single-ended against the reference.
// - Battery bit D0 selects battery measurement at any resolution.
// - Battery mode reports the raw divided-by-five code unscaled.
// - Normal mode rescales the battery code to the auxiliary transfer.
// - One port-scan request converts both auxiliary inputs and the battery input.
// - Port scan only accepted in host-controlled mode.
// - Buffer mode stores results in a 64-entry circular FIFO.
// - Buffer mode enabled by bit D7 of register 13.
// - One control bit selects host- or self-controlled operation.
// - Resolution of 8, 10 or 12 bits chosen by a two-bit field.
module sartmp_ctrl #(
	parameter int unsigned IRQ_CYC  = sartmp_pkg::IRQ_PULSE_CYC,
	parameter int unsigned TICK_CYC = sartmp_pkg::AUTO_TICK_CYC,
	parameter int unsigned DEPTH    = sartmp_pkg::BUF_DEPTH
) (
	input  wire logic                sys_clk,         // 10 MHz clock
	input  wire logic                srst,            // Sync reset, high
	input  sartmp_pkg::sartmp_avs_req_t avs_req,      // Avalon request
	output logic [31:0]              avs_readdata,    // Avalon read data
	output logic                     avs_waitrequest, // Avalon wait
	output sartmp_pkg::sartmp_adc_t  adc_ctl,         // Converter control
	input  wire logic                adc_done,        // Conversion done pin
	input  wire logic [11:0]         adc_code,        // Conversion code pins
	output logic                     gp_pin_a,        // Threshold pulse A
	output logic                     gp_pin_b         // Threshold pulse B
);
	import sartmp_pkg::*;

	localparam int unsigned IW = $clog2(IRQ_CYC + 1);
	localparam int unsigned TW = $clog2(TICK_CYC + 1);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned CW = AW + 1;

	typedef struct packed {
		logic              waitreq;
		logic [31:0]       rdata;
		logic              self_ctl;
		sartmp_res_t       res;
		logic              batt_mode;
		logic              buf_en;
		logic [15:0]       auto_cfg;
		logic [11:0]       tmin;
		logic [11:0]       tmax;
		logic              oor;
		logic [11:0]       res_a;
		logic [11:0]       res_b;
		logic [11:0]       res_v;
		logic [11:0]       res_t1;
		logic [11:0]       res_t2;
		sartmp_fn_t        seq;
		sartmp_ch_t        ch;
		sartmp_st_t        fsm;
		logic              auto_run;
		logic              refused;
		logic              start;
		logic              bias_hi;
		logic              done_s1;
		logic              done_s2;
		logic              done_s3;
		logic [11:0]       code_s1;
		logic [11:0]       code_s2;
		logic [TW-1:0]     tick_cnt;
		logic [7:0]        ivl_cnt;
		logic              auto_pend;
		logic [IW-1:0]     irq_cnt;
		logic              gp_a;
		logic              gp_b;
		logic [AW-1:0]     wp;
		logic [AW-1:0]     rp;
		logic [CW-1:0]     cnt;
	} sartmp_state_t;

	sartmp_state_t st_q;
	sartmp_state_t st_d;
	logic [11:0]   mem [DEPTH];
	logic [11:0]   scaled;
	logic          push;

	function automatic logic [15:0] be_merge(input logic [15:0] old,
	                                         input logic [31:0] wd,
	                                         input logic [3:0]  be);
		be_merge[7:0]  = be[0] ? wd[7:0]  : old[7:0];
		be_merge[15:8] = be[1] ? wd[15:8] : old[15:8];
	endfunction

	sartmp_scale u_scale (
		.code      (st_q.code_s2),
		.res       (st_q.res),
		.batt_mode (st_q.batt_mode),
		.is_vbat   (st_q.ch == CH_VBAT),
		.value     (scaled)
	);

	always_comb begin
		logic        req;
		logic        acc;
		logic        done_rise;
		logic        oor_set;
		logic        cmd_go;
		logic        legal;
		logic        pop;
		logic        full;
		logic [15:0] wv;
		sartmp_fn_t  fn;
		req       = avs_req.read | avs_req.write;
		acc       = req & ~st_q.waitreq;
		done_rise = st_q.done_s2 & ~st_q.done_s3;
		oor_set   = 1'b0;
		cmd_go    = 1'b0;
		legal     = 1'b0;
		pop       = 1'b0;
		full      = (st_q.cnt == CW'(DEPTH));
		wv        = 16'h0000;
		fn        = sartmp_fn_t'(avs_req.writedata[CMD_FN_LSB +: 4]);
		push      = 1'b0;
		st_d       = st_q;
		st_d.start = 1'b0;

		// Pin inputs pass two flops before any use
		st_d.done_s1 = adc_done;
		st_d.done_s2 = st_q.done_s1;
		st_d.done_s3 = st_q.done_s2;
		st_d.code_s1 = adc_code;
		st_d.code_s2 = st_q.code_s1;

		// One wait cycle, then the access completes with data ready
		st_d.waitreq = ~(req & st_q.waitreq);
		if (req && st_q.waitreq) begin
			st_d.rdata = 32'h0000_0000;
			unique case (avs_req.address)
				ADDR_CTRL: begin
					st_d.rdata[CTRL_SELF_BIT] = st_q.self_ctl;
					st_d.rdata[CTRL_RES_LSB +: 2] = st_q.res;
				end
				ADDR_CMD: begin
					st_d.rdata[CMD_FN_LSB +: 4] = st_q.seq;
					st_d.rdata[CMD_REFUSE_BIT] = st_q.refused;
					st_d.rdata[CMD_BUSY_BIT] = (st_q.fsm != ST_IDLE);
				end
				ADDR_BATT:   st_d.rdata[BATT_MODE_BIT] = st_q.batt_mode;
				ADDR_AUTO:   st_d.rdata[15:0] = st_q.auto_cfg;
				ADDR_TMIN:   st_d.rdata[11:0] = st_q.tmin;
				ADDR_TMAX:   st_d.rdata[11:0] = st_q.tmax;
				ADDR_TFLAG:  st_d.rdata[0] = st_q.oor;
				ADDR_RES_A:  st_d.rdata[11:0] = st_q.res_a;
				ADDR_RES_B:  st_d.rdata[11:0] = st_q.res_b;
				ADDR_RES_V:  st_d.rdata[11:0] = st_q.res_v;
				ADDR_RES_T1: st_d.rdata[11:0] = st_q.res_t1;
				ADDR_RES_T2: st_d.rdata[11:0] = st_q.res_t2;
				ADDR_BUF: begin
					st_d.rdata[BUF_EN_BIT] = st_q.buf_en;
					st_d.rdata[BUF_FULL_BIT] = full;
					st_d.rdata[BUF_EMPTY_BIT] = (st_q.cnt == '0);
				end
				ADDR_BUFDAT: begin
					st_d.rdata[11:0] = mem[st_q.rp];
					st_d.rdata[BDAT_FULL_BIT] = full;
					st_d.rdata[BDAT_EMPTY_BIT] = (st_q.cnt == '0);
				end
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end

		if (acc && avs_req.write) begin
			unique case (avs_req.address)
				ADDR_CTRL: if (avs_req.byteenable[0]) begin
					st_d.self_ctl = avs_req.writedata[CTRL_SELF_BIT];
					st_d.res = sartmp_res_t'(avs_req.writedata[CTRL_RES_LSB +: 2]);
				end
				ADDR_CMD: if (avs_req.byteenable[0]) begin
					cmd_go = (st_q.fsm == ST_IDLE);
				end
				ADDR_BATT: if (avs_req.byteenable[0]) begin
					st_d.batt_mode = avs_req.writedata[BATT_MODE_BIT];
				end
				ADDR_AUTO: st_d.auto_cfg = be_merge(st_q.auto_cfg,
				                                    avs_req.writedata, avs_req.byteenable);
				ADDR_TMIN: begin
					wv = be_merge({4'h0, st_q.tmin}, avs_req.writedata,
					              avs_req.byteenable);
					st_d.tmin = wv[11:0];
				end
				ADDR_TMAX: begin
					wv = be_merge({4'h0, st_q.tmax}, avs_req.writedata,
					              avs_req.byteenable);
					st_d.tmax = wv[11:0];
				end
				ADDR_BUF: if (avs_req.byteenable[0]) begin
					st_d.buf_en = avs_req.writedata[BUF_EN_BIT];
					if (!avs_req.writedata[BUF_EN_BIT]) begin
						// Leaving buffer mode rewinds the pointers
						st_d.wp  = '0;
						st_d.rp  = '0;
						st_d.cnt = '0;
					end
				end
				default: ;
			endcase
		end

		if (acc && avs_req.read && avs_req.address == ADDR_TFLAG) begin
			st_d.oor = 1'b0;
		end
		if (acc && avs_req.read && avs_req.address == ADDR_BUFDAT) begin
			pop = (st_q.cnt != '0);
		end

		// Temperature and scan conversions need host control; so does any buffer use
		if (cmd_go) begin
			unique case (fn)
				FN_TEMP,
				FN_TEMP_DIFF: legal = ~st_q.self_ctl;
				FN_SCAN:      legal = ~st_q.self_ctl;
				FN_AUX_A,
				FN_AUX_B,
				FN_VBAT:      legal = ~(st_q.self_ctl & st_q.buf_en);
				default:      legal = 1'b0;
			endcase
			st_d.refused = ~legal;
			if (legal) begin
				st_d.seq = fn;
				st_d.auto_run = 1'b0;
				st_d.fsm = ST_START;
				unique case (fn)
					FN_AUX_B:     st_d.ch = CH_AUX_B;
					FN_VBAT:      st_d.ch = CH_VBAT;
					FN_TEMP,
					FN_TEMP_DIFF: st_d.ch = CH_TEMP_LO;
					default:      st_d.ch = CH_AUX_A;
				endcase
			end
		end

		// Millisecond tick drives the auto interval
		if (st_q.tick_cnt == TW'(TICK_CYC - 1)) begin
			st_d.tick_cnt = '0;
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + TW'(1);
		end
		if (!st_q.auto_cfg[AUTO_EN_BIT]) begin
			st_d.ivl_cnt = 8'h00;
			st_d.auto_pend = 1'b0;
		end else if (st_q.tick_cnt == TW'(TICK_CYC - 1)) begin
			if (st_q.ivl_cnt == st_q.auto_cfg[AUTO_IVL_LSB +: 8]) begin
				st_d.ivl_cnt = 8'h00;
				st_d.auto_pend = 1'b1;
			end else begin
				st_d.ivl_cnt = st_q.ivl_cnt + 8'h01;
			end
		end
		// A pending auto run waits for idle and host control
		if (st_q.fsm == ST_IDLE && st_q.auto_pend && !cmd_go &&
		    !st_q.self_ctl && st_q.auto_cfg[AUTO_EN_BIT]) begin
			st_d.auto_pend = 1'b0;
			st_d.auto_run = 1'b1;
			st_d.seq = FN_TEMP;
			st_d.ch = CH_TEMP_LO;
			st_d.fsm = ST_START;
		end

		unique case (st_q.fsm)
			ST_IDLE: ;
			ST_START: begin
				st_d.start = 1'b1;
				st_d.bias_hi = (st_q.ch == CH_TEMP_HI);
				st_d.fsm = ST_WAIT;
			end
			ST_WAIT: if (done_rise) begin
				st_d.fsm = ST_STORE;
			end
			ST_STORE: begin
				unique case (st_q.ch)
					CH_AUX_A:   st_d.res_a = scaled;
					CH_AUX_B:   st_d.res_b = scaled;
					CH_VBAT:    st_d.res_v = scaled;
					CH_TEMP_LO: st_d.res_t1 = scaled;
					CH_TEMP_HI: st_d.res_t2 = scaled;
					default: ;
				endcase
				push = st_q.buf_en;
				if (st_q.auto_run && st_q.ch == CH_TEMP_LO) begin
					oor_set = (scaled < st_q.tmin) || (scaled > st_q.tmax);
				end
				st_d.fsm = ST_IDLE;
				if (st_q.seq == FN_SCAN && st_q.ch == CH_AUX_A) begin
					st_d.ch = CH_AUX_B;
					st_d.fsm = ST_START;
				end else if (st_q.seq == FN_SCAN && st_q.ch == CH_AUX_B) begin
					st_d.ch = CH_VBAT;
					st_d.fsm = ST_START;
				end else if (st_q.seq == FN_TEMP_DIFF &&
				             st_q.ch == CH_TEMP_LO) begin
					st_d.ch = CH_TEMP_HI;
					st_d.fsm = ST_START;
				end else begin
					st_d.auto_run = 1'b0;
				end
			end
			default: st_d.fsm = ST_IDLE;
		endcase

		// Set after clear so a same-cycle event survives the read
		if (oor_set) begin
			st_d.oor = 1'b1;
		end

		// No retrigger: a hit during a pulse must not stretch it
		if (oor_set && st_q.auto_cfg[AUTO_IRQ_BIT] &&
		    st_q.irq_cnt == '0) begin
			st_d.irq_cnt = IW'(IRQ_CYC);
		end else if (st_q.irq_cnt != '0) begin
			st_d.irq_cnt = st_q.irq_cnt - IW'(1);
		end
		st_d.gp_a = (st_d.irq_cnt != '0) & ~st_q.auto_cfg[AUTO_PIN_BIT];
		st_d.gp_b = (st_d.irq_cnt != '0) & st_q.auto_cfg[AUTO_PIN_BIT];

		// Full buffer overwrites the oldest entry
		if (pop) begin
			st_d.rp = st_q.rp + AW'(1);
		end
		if (push) begin
			st_d.wp = st_q.wp + AW'(1);
			if (full && !pop) begin
				st_d.rp = st_q.rp + AW'(1);
			end
		end
		if (push && !pop && !full) begin
			st_d.cnt = st_q.cnt + CW'(1);
		end else if (pop && !push) begin
			st_d.cnt = st_q.cnt - CW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q          <= '0;
			st_q.waitreq  <= 1'b1;
			st_q.self_ctl <= CTRL_RST[CTRL_SELF_BIT];
			st_q.res      <= sartmp_res_t'(CTRL_RST[CTRL_RES_LSB +: 2]);
			st_q.auto_cfg <= AUTO_RST;
			st_q.tmin     <= TMIN_RST;
			st_q.tmax     <= TMAX_RST;
			st_q.seq      <= FN_IDLE;
			st_q.ch       <= CH_AUX_A;
			st_q.fsm      <= ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Buffer storage carries no reset; only the pointers matter
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[st_q.wp] <= scaled;
		end
	end

	assign avs_readdata    = st_q.rdata;
	assign avs_waitrequest = st_q.waitreq;
	assign adc_ctl.start   = st_q.start;
	assign adc_ctl.chan    = st_q.ch;
	assign adc_ctl.bias_hi = st_q.bias_hi;
	assign adc_ctl.res     = st_q.res;
	assign gp_pin_a        = st_q.gp_a;
	assign gp_pin_b        = st_q.gp_b;

endmodule // sartmp_ctrl

// file: dv/sartmp_chk_asserts.sv
// Port checks for the auxiliary and temperature controller
`timescale 1ns/1ps
module sartmp_chk #(
	parameter int unsigned IRQ_CYC = sartmp_pkg::IRQ_PULSE_CYC
) (
	input wire logic                    sys_clk,         // Clock
	input wire logic                    srst,            // Reset
	input sartmp_pkg::sartmp_avs_req_t  avs_req,         // Bus request
	input wire logic                    avs_waitrequest, // Bus wait
	input sartmp_pkg::sartmp_adc_t      adc_ctl,         // Converter
	input wire logic                    gp_pin_a,        // Pulse A
	input wire logic                    gp_pin_b         // Pulse B
);
	import sartmp_pkg::*;
	logic [7:0]  ctrl_q;
	sartmp_ch_t  last_q;
	logic [15:0] hi_q;
	// Shadow of the control register so starts can be judged
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_q <= 8'h00;
			last_q <= CH_AUX_A;
			hi_q <= 16'h0000;
		end else begin
			if (avs_req.write && !avs_waitrequest &&
			    avs_req.address == ADDR_CTRL && avs_req.byteenable[0])
				ctrl_q <= avs_req.writedata[7:0];
			if (adc_ctl.start)
				last_q <= adc_ctl.chan;
			hi_q <= (gp_pin_a || gp_pin_b) ? hi_q + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	a_wait_one: assert property ((avs_req.read || avs_req.write) &&
		avs_waitrequest |=> !avs_waitrequest)
		else $error("bus access not answered after one wait");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_start_pulse: assert property (adc_ctl.start |=> !adc_ctl.start)
		else $error("start pulse longer than one cycle");
	a_bias_chan: assert property (adc_ctl.start |->
		adc_ctl.bias_hi == (adc_ctl.chan == CH_TEMP_HI))
		else $error("bias level does not match channel");
	a_diff_order: assert property (adc_ctl.start &&
		adc_ctl.chan == CH_TEMP_HI |-> last_q == CH_TEMP_LO)
		else $error("high current conversion without low first");
	a_temp_host: assert property (adc_ctl.start &&
		adc_ctl.chan inside {CH_TEMP_LO, CH_TEMP_HI} |-> !ctrl_q[7])
		else $error("temperature conversion in self mode");
	a_res_field: assert property (adc_ctl.start |->
		adc_ctl.res == ctrl_q[6:5])
		else $error("resolution differs from control field");
	a_pin_one: assert property (!(gp_pin_a && gp_pin_b))
		else $error("both pulse pins high");
	a_pulse_len: assert property ($fell(gp_pin_a || gp_pin_b) |->
		hi_q == IRQ_CYC)
		else $error("threshold pulse has wrong length");
endmodule // sartmp_chk

bind sartmp_ctrl sartmp_chk #(.IRQ_CYC(IRQ_CYC)) u_chk (
	.sys_clk(sys_clk), .srst(srst), .avs_req(avs_req),
	.avs_waitrequest(avs_waitrequest), .adc_ctl(adc_ctl),
	.gp_pin_a(gp_pin_a), .gp_pin_b(gp_pin_b));

// file: dv/sartmp_adc_model.sv
// Behavioural converter that answers start pulses
`timescale 1ns/1ps
module sartmp_adc_model (
	input wire logic               sys_clk, // Clock
	input sartmp_pkg::sartmp_adc_t adc_ctl, // Converter control
	input wire logic [11:0]        base,    // Code offset
	output logic                   done,    // Conversion done
	output logic [11:0]            code     // Conversion code
);
	import sartmp_pkg::*;
	initial begin
		done = 1'b0;
		code = 12'h000;
	end
	// Odd channels answer slowly; forked so back-to-back starts are seen
	task automatic answer(input sartmp_ch_t ch);
		repeat (ch[0] ? 9 : 3) @(posedge sys_clk);
		code <= base + 12'(ch);
		done <= 1'b1;
		repeat (6) @(posedge sys_clk);
		done <= 1'b0;
		// A code no longer held must not look valid
		code <= ~code;
	endtask
	always @(posedge sys_clk) begin
		if (adc_ctl.start)
			fork
				answer(adc_ctl.chan);
			join_none
	end
endmodule // sartmp_adc_model

// file: dv/testbench.sv
// Self-checking bench for the auxiliary and temperature controller
`timescale 1ns/1ps
module testbench;
	import sartmp_pkg::*;
	localparam int unsigned IRQ = 20;
	logic            sys_clk;
	logic            srst;
	sartmp_avs_req_t req;
	logic [31:0]     rdata;
	logic            wreq;
	sartmp_adc_t     adc;
	logic            done;
	logic [11:0]     code;
	logic [11:0]     base;
	logic            pa;
	logic            pb;
	int              fail_count;
	int              total_checks;
	sartmp_ctrl #(.IRQ_CYC(IRQ), .TICK_CYC(10), .DEPTH(BUF_DEPTH)) DUT (
		.sys_clk(sys_clk), .srst(srst), .avs_req(req),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .adc_ctl(adc),
		.adc_done(done), .adc_code(code), .gp_pin_a(pa), .gp_pin_b(pb));
	sartmp_adc_model u_adc (.sys_clk(sys_clk), .adc_ctl(adc),
		.base(base), .done(done), .code(code));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Request held until the edge where waitrequest is seen low
	task automatic bus(input logic rd_n, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		req <= '{address: a, read: rd_n, write: !rd_n, writedata: wd,
			byteenable: 4'hf};
		do begin
			@(posedge sys_clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		q = rdata;
		if (n >= 50)
			check(32'h0, 32'hdead);
		req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b1, a, 32'h0, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		rd(a, q);
		check(exp, q);
	endtask
	task automatic cmd(input sartmp_fn_t f);
		logic [31:0] q;
		wr(ADDR_CMD, {26'h0, f, 2'b00});
		repeat (3) @(posedge sys_clk);
		q = 32'h1;
		for (int i = 0; i < 100 && q[0] !== 1'b0; i++)
			rd(ADDR_CMD, q);
		check(32'h0, {31'h0, q[0]});
	endtask
	task automatic t_regs();
		rc(ADDR_CTRL, 32'h0);
		rc(ADDR_AUTO, 32'h0);
		rc(ADDR_TMIN, 32'h0);
		rc(ADDR_TMAX, 32'hfff);
		rc(ADDR_TFLAG, 32'h0);
		rc(ADDR_BUF, 32'h1);
		rc(8'h3c, 32'h0);
		$display("reset values done");
	endtask
	task automatic t_aux();
		logic [7:0] rs [3] = '{8'h20, 8'h40, 8'h00};
		for (int r = 0; r < 3; r++) begin
			wr(ADDR_CTRL, {24'h0, rs[r]});
			base <= 12'h0a0 + 12'(r);
			cmd(FN_AUX_A);
			rc(ADDR_RES_A, 32'h0a0 + r);
			cmd(FN_AUX_B);
			rc(ADDR_RES_B, 32'h0a1 + r);
		end
		$display("aux inputs done");
	endtask
	task automatic t_vbat();
		logic [7:0]  ct [4] = '{8'h20, 8'h20, 8'h20, 8'h40};
		logic [11:0] bs [4] = '{12'h020, 12'h040, 12'h040, 12'h080};
		logic [11:0] ex [4] = '{12'h0aa, 12'h0ff, 12'h042, 12'h28a};
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL, {24'h0, ct[i]});
			wr(ADDR_BATT, (i == 2) ? 32'h1 : 32'h0);
			base <= bs[i];
			cmd(FN_VBAT);
			rc(ADDR_RES_V, {20'h0, ex[i]});
		end
		wr(ADDR_BATT, 32'h0);
		$display("battery input done");
	endtask
	task automatic t_temp();
		logic [31:0] q;
		wr(ADDR_CTRL, 32'h0);
		base <= 12'h100;
		cmd(FN_TEMP);
		rc(ADDR_RES_T1, 32'h103);
		base <= 12'h200;
		cmd(FN_TEMP_DIFF);
		rc(ADDR_RES_T1, 32'h203);
		rc(ADDR_RES_T2, 32'h204);
		wr(ADDR_CTRL, 32'h80);
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_CMD, (i == 0) ? 32'h10 : 32'h18);
			rd(ADDR_CMD, q);
			check(32'h2, q & 32'h3);
		end
		rc(ADDR_RES_T1, 32'h203);
		wr(ADDR_CTRL, 32'h0);
		$display("temperature done");
	endtask
	task automatic t_scan();
		wr(ADDR_CTRL, 32'h20);
		base <= 12'h010;
		cmd(FN_SCAN);
		rc(ADDR_RES_A, 32'h010);
		rc(ADDR_RES_B, 32'h011);
		rc(ADDR_RES_V, 32'h05a);
		$display("port scan done");
	endtask
	task automatic t_auto();
		logic [11:0] bs [3] = '{12'h04d, 12'h000, 12'h022};
		logic [15:0] au [3] = '{16'h0007, 16'h0003, 16'h0103};
		int n;
		wr(ADDR_TMIN, 32'h020);
		wr(ADDR_TMAX, 32'h030);
		for (int k = 0; k < 3; k++) begin
			base <= bs[k];
			wr(ADDR_AUTO, {16'h0, au[k]});
			n = 0;
			for (int i = 0; i < 300 && !(pa || pb); i++)
				@(posedge sys_clk);
			while ((pa || pb) === 1'b1 && n < 100) begin
				check({31'h0, au[k][2]}, {31'h0, pb});
				n++;
				@(posedge sys_clk);
			end
			wr(ADDR_AUTO, 32'h0);
			repeat (40) @(posedge sys_clk);
			check((k < 2) ? IRQ : 0, n);
			rc(ADDR_TFLAG, (k < 2) ? 32'h1 : 32'h0);
			rc(ADDR_TFLAG, 32'h0);
		end
		$display("auto temperature done");
	endtask
	task automatic t_buf();
		logic [31:0] q;
		wr(ADDR_BUF, 32'h80);
		rc(ADDR_BUF, 32'h81);
		for (int i = 0; i <= BUF_DEPTH; i++) begin
			base <= 12'(i);
			cmd(FN_AUX_A);
		end
		rc(ADDR_BUF, 32'h82);
		for (int i = 1; i < 3; i++) begin
			rd(ADDR_BUFDAT, q);
			check(i, q & 32'hfff);
		end
		wr(ADDR_BUF, 32'h0);
		rc(ADDR_BUF, 32'h1);
		$display("buffer done");
	endtask
	initial begin
		fail_count = 0;
		total_checks = 0;
		req = '0;
		base = 12'h000;
		srst = 1'b1;
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs();
		t_aux();
		t_vbat();
		t_temp();
		t_scan();
		t_auto();
		t_buf();
		close_out();
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		fail_count++;
		close_out();
	end
endmodule // testbench
